// [tmr_pkg.sv]
// Shared constants, register map and carrier types of the multi-channel timer.
// Assumes a 10 MHz pclk and APB with 32-bit data and byte strobes.
package tmr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  // Register map; each channel owns one stride of words.
  localparam logic [11:0] OFF_COUNTER   = 12'h000;
  localparam logic [11:0] OFF_GENERAL   = 12'h004;
  localparam logic [11:0] OFF_DEDICATED = 12'h008;
  localparam logic [11:0] OFF_CONTROL   = 12'h00c;
  localparam logic [11:0] OFF_STATUS    = 12'h010;
  localparam logic [11:0] OFF_OUTMODE   = 12'h014;
  localparam logic [11:0] OFF_MASK      = 12'h018;
  localparam logic [11:0] CHAN_STRIDE   = 12'h020;
  localparam logic [11:0] OFF_START     = 12'h100;

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // Clear source codes.
  localparam logic [1:0] CLR_CAPTURE = 2'h1;
  localparam logic [1:0] CLR_MATCH   = 2'h2;
  // Compare output codes.
  localparam logic [1:0] OUT_LOW    = 2'h1;
  localparam logic [1:0] OUT_HIGH   = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;
  // Capture edge select bits.
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  // Field positions inside the 8-bit registers and the status word.
  localparam int CTL_CLR_LSB  = 5;
  localparam int CTL_EDGE_LSB = 0;
  localparam int OE_SEL_LSB   = 0;
  localparam int ST_CAP1      = 0;
  localparam int ST_OVF       = 8;
  localparam int ST_MATCH2    = 9;

  // Capture timing at the system clock rate.
  localparam int CLK_PERIOD_NS = 100;
  localparam int CAP_FLAG_NS   = 150;
  localparam int CAP_FLAG_CYC  = (CAP_FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] clear_source_sel;
    logic [1:0] capture_edge_sel;
    logic [1:0] output_level_sel;
  } tmr_chan_cfg_t;

  typedef struct packed {
    logic overflow_flag;
    logic second_match_flag;
    logic capture_one_flag;
  } tmr_evt_t;

endpackage

// [tmr_capture_sync.sv]
// Capture pin synchroniser and edge selector for one channel.
// Assumes the pin is asynchronous to pclk; the event pulse is one cycle long.
`timescale 1ns/1ns
module tmr_capture_sync
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Pin and selection
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  // Event
  output logic            evt
);

  logic sync1;
  logic sync2;
  logic prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // Edge codes: rising, falling or both.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= 1'b0;
    end else begin
      evt <= (edge_sel[EDGE_RISE_BIT] & sync2 & ~prev) |
             (edge_sel[EDGE_FALL_BIT] & ~sync2 & prev); // [R11]
    end
  end

endmodule

// [tmr_cmp_out.sv]
// Compare output pin driver for one channel.
// Assumes a one-cycle match pulse from the counter logic.
`timescale 1ns/1ns
module tmr_cmp_out
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Match and selection
  input  wire logic       match,
  input  wire logic [1:0] out_sel,
  // Pin
  output logic            pin_out
);

  // Driving the selected level again is harmless, so the pin stays put.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
    end else if (match) begin
      case (out_sel)
        OUT_HIGH:   pin_out <= 1'b1; // [R09] [R10]
        OUT_LOW:    pin_out <= 1'b0; // [R09] [R10]
        OUT_TOGGLE: pin_out <= ~pin_out; // [R09]
        default:    pin_out <= pin_out;
      endcase
    end
  end

endmodule

// [tmr_core.sv]
// Multi-channel 16-bit timer with an APB register slave.
// Assumes an APB master with byte strobes; capture pins are asynchronous.
//
// Operation
// [R01] 16-bit counters and compares take word or byte access.
// [R02] 8-bit registers pair: even upper, odd lower byte.
// [R03] Output enable/mode, start/aux, control high/low pair.
// [R04] Setting start bit restarts counter from zero.
// [R05] Reset leaves free-running mode, no clear source.
// [R06] Free-running wraps at all-ones, sets overflow flag.
// [R07] Dedicated match clears counter, sets match flag.
// [R08] Match clearing repeats count zero to compare value.
// [R09] Output code: 10 high, 01 low, 11 toggle.
// [R10] Pin already at selected level stays unchanged.
// [R11] Capture edge code: 01 rise, 10 fall, 11 both.
// [R12] Counter value moves to general register one cycle later.
// [R13] Capture flag sets one and a half cycles later; the code sets it two cycles after the capture event, one after the transfer.
// [R14] Source holds capture pulses one and half cycles.
// [R15] Clear source: 01 capture, 10 dedicated match.
// [R16] On capture clear, store first, then clear.
// [R17] Start bit zero halts, one counts; reset zero.
// [R18] Byte write changes only its own half.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module tmr_core
  import tmr_pkg::*;
#(
  parameter int N_CH = 7
)
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Interrupt
  output logic                   irq,
  // Timer pins
  input  wire logic [N_CH-1:0]   cap_in,
  output logic      [N_CH-1:0]   cmp_out
);

  localparam int PIPE_W = (CAP_FLAG_CYC > 1) ? CAP_FLAG_CYC - 1 : 1;

  logic [CNT_W-1:0] channel_counter             [N_CH];
  logic [CNT_W-1:0] general_compare_capture_reg [N_CH];
  logic [CNT_W-1:0] dedicated_compare_reg       [N_CH];
  logic [7:0]       control_high_reg            [N_CH];
  logic [7:0]       control_low_reg             [N_CH];
  logic [7:0]       output_enable_reg           [N_CH];
  logic [7:0]       timer_mode_reg              [N_CH];
  logic [15:0]      status                      [N_CH];
  logic [15:0]      irq_mask                    [N_CH];
  logic [PIPE_W-1:0] flag_pipe                  [N_CH];
  logic [N_CH-1:0]  counter_run_bit;
  logic [N_CH-1:0]  run_q;
  logic [7:0]       chan1_aux_control_reg;

  tmr_chan_cfg_t    cfg [N_CH];
  tmr_evt_t         evt [N_CH];
  logic [N_CH-1:0]  cap_evt;
  logic [N_CH-1:0]  match1;
  logic [N_CH-1:0]  match2;
  logic [N_CH-1:0]  stat_rd;

  logic             acc_done;
  logic             wr_en;
  logic             rd_en;
  logic             setup;
  logic [DATA_W-1:0] next_rdata;
  logic             next_err;
  logic [N_CH-1:0]  next_stat_rd;

  function automatic logic [11:0] reg_addr(input int c, input logic [11:0] off);
    reg_addr = 12'(CHAN_STRIDE * 12'(c)) + off;
  endfunction

  // Byte strobes choose which half of a 16-bit register is written.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]}; // [R18]
  endfunction

  function automatic logic hit(input int c, input logic [11:0] off);
    hit = (paddr == reg_addr(c, off));
  endfunction

  assign setup    = psel & ~penable;
  assign acc_done = psel & penable & pready;
  assign wr_en    = acc_done & pwrite;
  assign rd_en    = acc_done & ~pwrite;

  // Zero-wait slave: pready rises in the cycle after setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Read data is sampled at setup so it stands steady during the access phase.
  always_comb begin
    next_rdata   = '0;
    next_err     = 1'b1;
    next_stat_rd = '0;
    if (paddr == OFF_START) begin
      next_rdata[15:8] = 8'(counter_run_bit); // [R03]
      next_rdata[7:0]  = chan1_aux_control_reg;
      next_err         = 1'b0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (hit(c, OFF_COUNTER)) begin
          next_rdata[15:0] = channel_counter[c]; // [R01]
          next_err         = 1'b0;
        end else if (hit(c, OFF_GENERAL)) begin
          next_rdata[15:0] = general_compare_capture_reg[c];
          next_err         = 1'b0;
        end else if (hit(c, OFF_DEDICATED)) begin
          next_rdata[15:0] = dedicated_compare_reg[c];
          next_err         = 1'b0;
        end else if (hit(c, OFF_CONTROL)) begin
          next_rdata[15:0] = {control_high_reg[c], control_low_reg[c]}; // [R02] [R03]
          next_err         = 1'b0;
        end else if (hit(c, OFF_STATUS)) begin
          next_rdata[15:0] = status[c]; // [R03]
          next_err         = 1'b0;
          next_stat_rd[c]  = ~pwrite;
        end else if (hit(c, OFF_OUTMODE)) begin
          next_rdata[15:0] = {output_enable_reg[c], timer_mode_reg[c]}; // [R03]
          next_err         = 1'b0;
        end else if (hit(c, OFF_MASK)) begin
          next_rdata[15:0] = irq_mask[c];
          next_err         = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
      stat_rd <= '0;
    end else if (setup) begin
      prdata  <= pwrite ? '0 : next_rdata;
      pslverr <= next_err;
      stat_rd <= next_stat_rd;
    end else if (acc_done) begin
      pslverr <= 1'b0;
      stat_rd <= '0;
    end
  end

  // Start register and its lower-byte partner.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_run_bit       <= '0; // [R17]
      chan1_aux_control_reg <= BYTE_RESET;
    end else if (wr_en && paddr == OFF_START) begin
      if (pstrb[1]) begin
        counter_run_bit <= pwdata[8 +: N_CH]; // [R02] [R03]
      end
      if (pstrb[0]) begin
        chan1_aux_control_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= '0;
    end else begin
      run_q <= counter_run_bit;
    end
  end

  // Per-channel 8-bit configuration pairs and the 16-bit interrupt mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < N_CH; c++) begin
        control_high_reg[c]  <= BYTE_RESET;
        control_low_reg[c]   <= BYTE_RESET; // [R05]
        output_enable_reg[c] <= BYTE_RESET;
        timer_mode_reg[c]    <= BYTE_RESET;
        irq_mask[c]          <= '0;
      end
    end else if (wr_en) begin
      for (int c = 0; c < N_CH; c++) begin
        if (hit(c, OFF_CONTROL)) begin
          if (pstrb[1]) control_high_reg[c] <= pwdata[15:8]; // [R02]
          if (pstrb[0]) control_low_reg[c] <= pwdata[7:0];
        end else if (hit(c, OFF_OUTMODE)) begin
          if (pstrb[1]) output_enable_reg[c] <= pwdata[15:8]; // [R03]
          if (pstrb[0]) timer_mode_reg[c] <= pwdata[7:0];
        end else if (hit(c, OFF_MASK)) begin
          irq_mask[c] <= merge16(irq_mask[c], pwdata[15:0], pstrb[1:0]);
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      cfg[c].clear_source_sel = control_low_reg[c][CTL_CLR_LSB +: 2]; // [R15]
      cfg[c].capture_edge_sel = control_low_reg[c][CTL_EDGE_LSB +: 2];
      cfg[c].output_level_sel = output_enable_reg[c][OE_SEL_LSB +: 2];
      match1[c] = counter_run_bit[c] &&
                  channel_counter[c] == general_compare_capture_reg[c];
      match2[c] = counter_run_bit[c] && channel_counter[c] == dedicated_compare_reg[c];
      evt[c].second_match_flag = match2[c]; // [R07]
      evt[c].overflow_flag     = counter_run_bit[c] && run_q[c] &&
                                 channel_counter[c] == CNT_MAX &&
                                 !(cfg[c].clear_source_sel == CLR_MATCH && match2[c]) &&
                                 !(cfg[c].clear_source_sel == CLR_CAPTURE && cap_evt[c]) &&
                                 !(wr_en && hit(c, OFF_COUNTER)); // [R06]
      evt[c].capture_one_flag  = flag_pipe[c][PIPE_W-1]; // [R13]
    end
  end

  // Counters: a bus write wins, then restart, then clearing, then counting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < N_CH; c++) begin
        channel_counter[c] <= CNT_ZERO;
      end
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (wr_en && hit(c, OFF_COUNTER)) begin
          channel_counter[c] <= merge16(channel_counter[c], pwdata[15:0], pstrb[1:0]); // [R01]
        end else if (counter_run_bit[c] && !run_q[c]) begin
          channel_counter[c] <= CNT_ZERO; // [R04]
        end else if (counter_run_bit[c]) begin // [R17]
          if (cfg[c].clear_source_sel == CLR_CAPTURE && cap_evt[c]) begin
            channel_counter[c] <= CNT_ZERO; // [R15] [R16]
          end else if (cfg[c].clear_source_sel == CLR_MATCH && match2[c]) begin
            channel_counter[c] <= CNT_ZERO; // [R07] [R08]
          end else begin
            channel_counter[c] <= channel_counter[c] + 16'h0001; // [R06]
          end
        end
      end
    end
  end

  // The captured value is the count one cycle after the pin was latched, and
  // it is stored on the same edge that clears the counter, so the old count wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < N_CH; c++) begin
        general_compare_capture_reg[c] <= CNT_ZERO;
        dedicated_compare_reg[c]       <= CNT_MAX;
      end
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (wr_en && hit(c, OFF_GENERAL)) begin
          general_compare_capture_reg[c] <= merge16(general_compare_capture_reg[c],
                                                    pwdata[15:0], pstrb[1:0]); // [R01]
        end else if (cap_evt[c]) begin
          general_compare_capture_reg[c] <= channel_counter[c]; // [R12] [R16]
        end
        if (wr_en && hit(c, OFF_DEDICATED)) begin
          dedicated_compare_reg[c] <= merge16(dedicated_compare_reg[c],
                                              pwdata[15:0], pstrb[1:0]); // [R18]
        end
      end
    end
  end

  // The flag trails the transfer; one and a half cycles round up to whole cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < N_CH; c++) begin
        flag_pipe[c] <= '0;
      end
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        flag_pipe[c] <= PIPE_W'({flag_pipe[c], cap_evt[c]}); // [R13]
      end
    end
  end

  // Sticky status: a read clears only what it returned, and a new event wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < N_CH; c++) begin
        status[c] <= '0;
      end
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        logic [15:0] clr;
        logic [15:0] set;
        clr = (rd_en && stat_rd[c]) ? prdata[15:0] : '0;
        set = '0;
        set[ST_OVF]    = evt[c].overflow_flag; // [R06]
        set[ST_MATCH2] = evt[c].second_match_flag; // [R07]
        set[ST_CAP1]   = evt[c].capture_one_flag; // [R13]
        status[c] <= (status[c] & ~clr) | set;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= 1'b0;
      for (int c = 0; c < N_CH; c++) begin
        if (|(status[c] & irq_mask[c])) begin
          irq <= 1'b1;
        end
      end
    end
  end

  for (genvar g = 0; g < N_CH; g++) begin : g_chan
    tmr_capture_sync u_cap (
      .pclk     (pclk),
      .presetn  (presetn),
      .pin      (cap_in[g]), // [R14]
      .edge_sel (cfg[g].capture_edge_sel),
      .evt      (cap_evt[g])
    );

    tmr_cmp_out u_out (
      .pclk    (pclk),
      .presetn (presetn),
      .match   (match1[g]),
      .out_sel (cfg[g].output_level_sel),
      .pin_out (cmp_out[g])
    );
  end

endmodule

// [tmr_core_assertions.sv]
// Port checker for the multi-channel timer core.
// Assumes the APB slave answers in the cycle after setup.
`timescale 1ns/1ns
module tmr_core_assertions
  import tmr_pkg::*;
#(
  parameter int N_CH = 7
)
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Interrupt and pins
  input wire logic              irq,
  input wire logic [N_CH-1:0]   cap_in,
  input wire logic [N_CH-1:0]   cmp_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_ANSWER: assert property (psel && !penable |=> pready)
    else $error("No answer after setup.");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("Ready outside access phase.");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("Ready held too long.");
  AST_HOLD_DATA: assert property (pready |=> $stable(prdata))
    else $error("Read data moved before next setup.");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("Upper read half not zero.");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("Refused read returned data.");
  AST_ERR_IN_ACCESS: assert property (pslverr |-> pready)
    else $error("Error without ready.");
  AST_QUIET_START: assert property ($rose(presetn) |-> cmp_out == '0 && !irq)
    else $error("Outputs active after reset.");
endmodule

bind tmr_core tmr_core_assertions #(.N_CH(N_CH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .cap_in(cap_in), .cmp_out(cmp_out));

// [tmr_pin_src.sv]
// Capture pin source standing in for the outside world.
// Assumes the bench asks for levels; each level is held at least two clocks.
`timescale 1ns/1ns
module tmr_pin_src #(
  parameter int N_CH = 7
)
(
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Requested and driven levels
  input  wire logic [N_CH-1:0] want,
  output logic      [N_CH-1:0] cap
);
  logic [N_CH-1:0][1:0] age;

  // A request that comes too soon waits, so no pulse is ever too short.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= '0;
      age <= '0;
    end else begin
      for (int i = 0; i < N_CH; i++) begin
        if (want[i] != cap[i] && age[i] == 2'h2) begin
          cap[i] <= want[i];
          age[i] <= 2'h0;
        end else if (age[i] != 2'h2) begin
          age[i] <= age[i] + 2'h1;
        end
      end
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the timer core over APB.
// Assumes the checker is bound to the core and the pin source drives captures.
`timescale 1ns/1ns
module tb_top;
  import tmr_pkg::*;
  localparam logic [11:0] C1 = 12'h020;
  localparam logic [11:0] C2 = 12'h040;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic [3:0]        pstrb;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic [6:0]        cap_in;
  logic [6:0]        cmp_out;
  logic [6:0]        want;
  logic [15:0]       exp_q[$];
  logic [31:0]       lfsr;
  logic [15:0]       ev;
  logic [1:0]        st;
  logic              prev;
  int                fail_count;
  int                comparisons;
  int                cyc;
  int                n;

  tmr_core #(.N_CH(7)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .cap_in(cap_in), .cmp_out(cmp_out));
  tmr_pin_src #(.N_CH(7)) u_src (
    .pclk(pclk), .presetn(presetn), .want(want), .cap(cap_in));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // One transfer; an idle edge follows so the next request starts cleanly.
  task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wrs(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    apb(a, 1'b1, d, s);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(a, 1'b1, d, 4'h3);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 16'h0000, 4'h0);
  endtask

  // Read results are matched against the oldest noted expectation.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk(exp_q.pop_front(), prdata[15:0]);
    end
    // Only the one unmapped address in the stimulus may be refused.
    if (psel && penable && pready === 1'b1) begin
      chk({15'h0000, paddr == 12'h200}, {15'h0000, pslverr});
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, want} = '0;
    presetn = 1'b0;
    lfsr = 32'h0001290b;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_COUNTER, CNT_ZERO);
    rd(OFF_DEDICATED, CNT_MAX);
    rd(OFF_CONTROL, 16'h0000);
    rd(OFF_START, 16'h0000);
    ev = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      st = (lfsr[17:16] == 2'h0) ? 2'h3 : lfsr[17:16];
      wrs(OFF_GENERAL, lfsr[15:0], {2'h0, st});
      ev = {st[1] ? lfsr[15:8] : ev[15:8], st[0] ? lfsr[7:0] : ev[7:0]};
      rd(OFF_GENERAL, ev);
    end
    wr(OFF_OUTMODE, 16'h0300);
    wrs(OFF_OUTMODE, 16'h0000, 4'h1);
    rd(OFF_OUTMODE, 16'h0300);
    wr(12'h200, 16'hffff);
    rd(12'h200, 16'h0000);
    wr(OFF_OUTMODE, 16'h0000);
    wr(OFF_DEDICATED, 16'h8000);
    wr(OFF_MASK, 16'h0100);
    wr(OFF_START, 16'h0100);
    wr(OFF_COUNTER, 16'hfffd);
    repeat (6) @(posedge pclk);
    chk(16'h0001, {15'h0000, irq});
    rd(OFF_STATUS, 16'h0100);
    repeat (2) @(posedge pclk);
    chk(16'h0000, {15'h0000, irq});
    rd(OFF_STATUS, 16'h0000);
    wr(OFF_CONTROL, {8'h00, 1'b0, CLR_MATCH, 5'h00});
    wr(OFF_DEDICATED, 16'h0010);
    wr(OFF_COUNTER, 16'h0000);
    repeat (40) @(posedge pclk);
    rd(OFF_STATUS, 16'h0200);
    wr(C1 + OFF_DEDICATED, 16'h0020);
    wr(C1 + OFF_GENERAL, 16'h0005);
    wr(C1 + OFF_CONTROL, {8'h00, 1'b0, CLR_MATCH, 5'h00});
    wr(OFF_START, 16'h0700);
    for (int i = 0; i < 4; i++) begin
      wr(C1 + OFF_OUTMODE, {6'h00, (i < 2) ? OUT_HIGH : OUT_LOW, 8'h00});
      repeat (40) @(posedge pclk);
      chk({15'h0000, i < 2}, {15'h0000, cmp_out[1]});
    end
    wr(C1 + OFF_OUTMODE, {6'h00, OUT_TOGGLE, 8'h00});
    n = 0;
    prev = cmp_out[1];
    repeat (99) begin
      @(posedge pclk);
      if (cmp_out[1] !== prev) n++;
      prev = cmp_out[1];
    end
    chk(16'h0003, n[15:0]);
    for (int k = 1; k < 4; k++) begin
      wr(C2 + OFF_CONTROL, {8'h00, 1'b0, CLR_CAPTURE, 3'h0, k[1:0]});
      repeat (4) begin
        want[2] <= ~want[2];
        repeat (10) @(posedge pclk);
      end
      rd(C2 + OFF_GENERAL, (k == 3) ? 16'h0009 : 16'h0013);
      rd(C2 + OFF_STATUS, 16'h0001);
    end
    give_verdict();
  end
endmodule
